// File: src/dwt_top.v
// main and deep-sleep watchdog with APB registers
// Function
// - main watchdog ticks from low-power RC oscillator
// - prescaler divides by 32 or 128
// - prescaler output is the base time unit
// - 4-bit postscaler, sixteen ratios up to 32768
// - reset clears all counters; clock switch clears the main watchdog counters
// - power-save entry and exit clear counters
// - clear instruction restarts counter and scalers
// - time-out in sleep or idle wakes device
// - sleep and idle flags stay set after wake
// - time-out flag sticky until software clears it
// - windowed clear accepted only in last quarter
// - early windowed clear causes watchdog reset
// - window mode active when window-disable is zero
// - hardware enable forces watchdog always on
// - else software enable bit, cleared on reset
// - deep watchdog runs in deep sleep, selectable clock
// - clock-select one picks RC, zero secondary
// - deep watchdog 4-bit postscale selects time-out
// - deep prescale 32, postscale ratio 2^(2k+1)
// - deep enable enables its clock, wakes device
`timescale 1ns/100ps
`default_nettype none
`include "dwt_map.vh"
module dwt_top #(
	parameter POST_W      = 15,
	parameter DEEP_POST_W = 31
) (
	input  wire                   mclk,
	input  wire                   rstn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`DWT_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output wire                   pready,
	output wire                   pslverr,
	input  wire                   low_power_rc_osc,
	input  wire                   secondary_osc,
	input  wire                   clear_watchdog_instruction,
	input  wire                   power_save_instruction,
	input  wire                   power_save_idle,
	input  wire                   wake_event,
	input  wire                   osc_switch_done,
	input  wire                   deep_sleep_active,
	output reg                    wdt_reset_request,
	output reg                    wdt_wake_up,
	output reg                    deep_wdt_wake_up,
	output wire                   low_power_rc_osc_enable,
	output wire                   secondary_osc_enable,
	output wire                   power_mode_sleep,
	output wire                   power_mode_idle
);

	localparam MODE_RUN   = 2'b00;
	localparam MODE_SLEEP = 2'b01;
	localparam MODE_IDLE  = 2'b10;

	reg  [1:0]                rst_sync_reg;
	wire                      rst_n;
	reg  [1:0]                low_power_rc_osc_sync_reg;
	reg  [1:0]                secondary_osc_sync_reg;
	reg                       low_power_rc_osc_last_reg;
	reg                       secondary_osc_last_reg;
	wire                      low_power_rc_osc_tick;
	wire                      secondary_osc_tick;

	reg  [`DWT_CTRL_W-1:0]    ctrl_reg;
	reg                       sw_en_reg;
	reg                       timeout_flag_reg;
	reg                       sleep_flag_reg;
	reg                       idle_flag_reg;
	reg  [1:0]                mode_reg;
	reg  [1:0]                mode_next;

	wire                      apb_setup;
	wire                      apb_write;
	wire                      addr_ok;
	wire                      wr_ctrl;
	wire                      wr_status;
	reg  [31:0]               rd_value;

	wire [3:0]                wdt_postscale_select;
	wire                      wdt_prescale_select;
	wire                      window_disable;
	wire                      wdt_hw_enable;
	wire [3:0]                deep_wdt_postscale_select;
	wire                      deep_wdt_clock_select;
	wire                      deep_wdt_enable;
	wire                      wdt_enabled;
	wire                      running;

	wire [4:0]                pre_log2;
	wire [4:0]                post_log2;
	wire [6:0]                pre_cnt;
	wire [POST_W-1:0]         post_cnt;
	wire                      wdt_timeout;
	wire                      clear_watchdog_instruction_run;
	wire                      window_open;
	wire                      clear_early;
	wire                      enter_save;
	wire                      leave_save;
	wire                      wdt_clear;
	wire                      wake_clear;
	wire                      clr_timeout;
	wire                      clr_sleep;
	wire                      clr_idle;
	wire [22:0]               elapsed;
	wire [22:0]               total;
	wire [22:0]               threshold;
	wire [POST_W-1:0]         post_max;
	wire [6:0]                pre_max;

	wire                      deep_tick;
	wire                      deep_run;
	wire [4:0]                deep_post_log2;
	wire [6:0]                deep_pre_cnt;
	wire [DEEP_POST_W-1:0]    deep_post_cnt;
	wire                      deep_timeout;

	// reset release through two flops
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// oscillator pins are asynchronous; ticks come from the synchronised copy only
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_power_rc_osc_sync_reg <= 2'b00;
			secondary_osc_sync_reg <= 2'b00;
			low_power_rc_osc_last_reg <= 1'b0;
			secondary_osc_last_reg <= 1'b0;
		end else begin
			low_power_rc_osc_sync_reg <= {low_power_rc_osc_sync_reg[0], low_power_rc_osc};
			secondary_osc_sync_reg <= {secondary_osc_sync_reg[0], secondary_osc};
			low_power_rc_osc_last_reg <= low_power_rc_osc_sync_reg[1];
			secondary_osc_last_reg <= secondary_osc_sync_reg[1];
		end
	end
	assign low_power_rc_osc_tick = low_power_rc_osc_sync_reg[1] && !low_power_rc_osc_last_reg;
	assign secondary_osc_tick = secondary_osc_sync_reg[1] && !secondary_osc_last_reg;

	assign wdt_postscale_select      = ctrl_reg[`DWT_CTRL_POST_MSB:`DWT_CTRL_POST_LSB];
	assign wdt_prescale_select       = ctrl_reg[`DWT_CTRL_PRESEL];
	assign window_disable            = ctrl_reg[`DWT_CTRL_WINDOW_DISABLE];
	assign wdt_hw_enable             = ctrl_reg[`DWT_CTRL_HWEN];
	assign deep_wdt_postscale_select = ctrl_reg[`DWT_CTRL_DPOST_MSB:`DWT_CTRL_DPOST_LSB];
	assign deep_wdt_clock_select     = ctrl_reg[`DWT_CTRL_DCLKSEL];
	assign deep_wdt_enable           = ctrl_reg[`DWT_CTRL_DEN];

	// APB slave, zero wait states
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;
	assign addr_ok   = (paddr == `DWT_OFF_CTRL) || (paddr == `DWT_OFF_STATUS) ||
	                   (paddr == `DWT_OFF_WDT_COUNT) || (paddr == `DWT_OFF_DEEP_COUNT);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;
	assign wr_ctrl   = apb_write && (paddr == `DWT_OFF_CTRL);
	assign wr_status = apb_write && (paddr == `DWT_OFF_STATUS);

	always @* begin
		rd_value = 32'h0000_0000;
		if (paddr == `DWT_OFF_CTRL) begin
			rd_value[`DWT_CTRL_W-1:0] = ctrl_reg;
		end else if (paddr == `DWT_OFF_STATUS) begin
			rd_value[`DWT_STAT_IDLE]    = idle_flag_reg;
			rd_value[`DWT_STAT_SLEEP]   = sleep_flag_reg;
			rd_value[`DWT_STAT_TIMEOUT] = timeout_flag_reg;
			rd_value[`DWT_STAT_SWEN]    = sw_en_reg;
		end else if (paddr == `DWT_OFF_WDT_COUNT) begin
			rd_value[22:0] = elapsed;
		end else if (paddr == `DWT_OFF_DEEP_COUNT) begin
			rd_value[DEEP_POST_W-1:0] = deep_post_cnt;
		end
	end

	// read data latched in setup, stable through the access phase
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (apb_setup && !pwrite)
			prdata <= rd_value;
	end

	// unused control bits are not stored, so they read back as zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ctrl_reg <= `DWT_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_reg <= pwdata[`DWT_CTRL_W-1:0] & `DWT_CTRL_WMASK;
	end

	// clearing the software enable cannot switch off a hardware-enabled watchdog
	assign wdt_enabled = wdt_hw_enable || sw_en_reg;
	assign running     = (mode_reg == MODE_RUN);

	// main watchdog divider
	assign pre_log2  = wdt_prescale_select ? `DWT_PRE_LONG_LOG2 : `DWT_PRE_SHORT_LOG2;
	assign post_log2 = {1'b0, wdt_postscale_select};

	assign enter_save  = running && power_save_instruction;
	assign leave_save  = !running && (wake_event || wdt_timeout);
	assign clear_watchdog_instruction_run  = running && clear_watchdog_instruction && wdt_enabled;
	assign clear_early = clear_watchdog_instruction_run && !window_disable && !window_open;

	// position in the period for the window check
	assign pre_max   = ~(7'h7F << pre_log2);
	assign post_max  = ~({POST_W{1'b1}} << post_log2);
	assign elapsed   = ({{(23-POST_W){1'b0}}, post_cnt} << pre_log2) | {16'h0000, pre_cnt};
	assign total     = (({{(23-POST_W){1'b0}}, post_max} << pre_log2) | {16'h0000, pre_max}) +
	                   23'h000001;
	assign threshold = total - (total >> 2);
	assign window_open = (elapsed >= threshold);

	// a time-out wake already wraps the divider to zero; feeding the time-out
	// back into the clear would close a loop through the divider
	assign wake_clear = !running && wake_event;

	// every restart source; an accepted or early clear both restart the count
	assign wdt_clear = !wdt_enabled || osc_switch_done || enter_save || wake_clear ||
	                   clear_watchdog_instruction_run;

	dwt_divider #(
		.PRE_W  (7),
		.POST_W (POST_W)
	) main_div (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (low_power_rc_osc_tick),
		.clear     (wdt_clear),
		.pre_log2  (pre_log2),
		.post_log2 (post_log2),
		.pre_cnt   (pre_cnt),
		.post_cnt  (post_cnt),
		.timeout   (wdt_timeout)
	);

	// power-save mode tracking
	always @* begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_RUN: begin
				if (enter_save)
					mode_next = power_save_idle ? MODE_IDLE : MODE_SLEEP;
			end
			MODE_SLEEP, MODE_IDLE: begin
				if (leave_save)
					mode_next = MODE_RUN;
			end
			default: begin
				mode_next = MODE_RUN;
			end
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= MODE_RUN;
		else
			mode_reg <= mode_next;
	end
	assign power_mode_sleep = (mode_reg == MODE_SLEEP);
	assign power_mode_idle  = (mode_reg == MODE_IDLE);

	// status flags: hardware set beats a software clear in the same cycle
	assign clr_timeout = wr_status && !pwdata[`DWT_STAT_TIMEOUT];
	assign clr_sleep   = wr_status && !pwdata[`DWT_STAT_SLEEP];
	assign clr_idle    = wr_status && !pwdata[`DWT_STAT_IDLE];

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sw_en_reg        <= 1'b0;
			timeout_flag_reg <= 1'b0;
			sleep_flag_reg   <= 1'b0;
			idle_flag_reg    <= 1'b0;
		end else begin
			if (wr_status)
				sw_en_reg <= pwdata[`DWT_STAT_SWEN];
			timeout_flag_reg <= wdt_timeout || clear_early ||
			                    (timeout_flag_reg && !clr_timeout);
			// wake leaves these alone; only software clears them
			sleep_flag_reg <= (enter_save && !power_save_idle) ||
			                  (sleep_flag_reg && !clr_sleep);
			idle_flag_reg  <= (enter_save && power_save_idle) ||
			                  (idle_flag_reg && !clr_idle);
		end
	end

	// time-out resets in run mode, wakes in sleep or idle
	// registered, so a settling time-out term never glitches the reset line
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_reset_request <= 1'b0;
			wdt_wake_up       <= 1'b0;
		end else begin
			wdt_reset_request <= (running && wdt_timeout) || clear_early;
			wdt_wake_up       <= !running && wdt_timeout;
		end
	end

	// deep-sleep watchdog
	// counters held at zero outside deep sleep, so every entry starts a full period
	assign deep_tick      = deep_wdt_clock_select ? low_power_rc_osc_tick : secondary_osc_tick;
	assign deep_run       = deep_wdt_enable && deep_sleep_active;
	assign deep_post_log2 = {deep_wdt_postscale_select, 1'b1};

	dwt_divider #(
		.PRE_W  (7),
		.POST_W (DEEP_POST_W)
	) deep_div (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (deep_tick),
		.clear     (!deep_run),
		.pre_log2  (`DWT_DEEP_PRE_LOG2),
		.post_log2 (deep_post_log2),
		.pre_cnt   (deep_pre_cnt),
		.post_cnt  (deep_post_cnt),
		.timeout   (deep_timeout)
	);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			deep_wdt_wake_up <= 1'b0;
		else
			deep_wdt_wake_up <= deep_timeout;
	end

	// a watchdog enable also switches on its clock source
	assign low_power_rc_osc_enable = wdt_enabled || (deep_wdt_enable && deep_wdt_clock_select);
	assign secondary_osc_enable    = deep_wdt_enable && !deep_wdt_clock_select;

endmodule
`default_nettype wire

// File: src/dwt_map.vh
// register map, field positions, reset values and divider constants of the dual watchdog
`ifndef DWT_MAP_VH
`define DWT_MAP_VH

`define DWT_ADDR_W          12
`define DWT_OFF_CTRL        12'h000
`define DWT_OFF_STATUS      12'h004
`define DWT_OFF_WDT_COUNT   12'h008
`define DWT_OFF_DEEP_COUNT  12'h00C

`define DWT_CTRL_POST_LSB   0
`define DWT_CTRL_POST_MSB   3
`define DWT_CTRL_PRESEL     4
`define DWT_CTRL_WINDOW_DISABLE     6
`define DWT_CTRL_HWEN       7
`define DWT_CTRL_DPOST_LSB  8
`define DWT_CTRL_DPOST_MSB  11
`define DWT_CTRL_DCLKSEL    12
`define DWT_CTRL_DEN        15
`define DWT_CTRL_W          16
`define DWT_CTRL_RESET      16'h9FDF
`define DWT_CTRL_WMASK      16'h9FDF

`define DWT_STAT_IDLE       2
`define DWT_STAT_SLEEP      3
`define DWT_STAT_TIMEOUT    4
`define DWT_STAT_SWEN       5

`define DWT_PRE_SHORT_LOG2  5'h05
`define DWT_PRE_LONG_LOG2   5'h07
`define DWT_DEEP_PRE_LOG2   5'h05

`endif

// File: src/dwt_divider.v
// prescaler and postscaler chain counting oscillator ticks up to a time-out
`timescale 1ns/100ps
`default_nettype none
module dwt_divider #(
	parameter PRE_W  = 7,
	parameter POST_W = 15
) (
	input  wire              mclk,
	input  wire              rst_n,
	input  wire              tick,
	input  wire              clear,
	input  wire [4:0]        pre_log2,
	input  wire [4:0]        post_log2,
	output wire [PRE_W-1:0]  pre_cnt,
	output wire [POST_W-1:0] post_cnt,
	output wire              timeout
);

	reg  [PRE_W-1:0]  pre_reg;
	reg  [POST_W-1:0] post_reg;
	wire [PRE_W-1:0]  pre_max;
	wire [POST_W-1:0] post_max;
	wire              pre_wrap;

	assign pre_max  = ~({PRE_W{1'b1}} << pre_log2);
	assign post_max = ~({POST_W{1'b1}} << post_log2);
	assign pre_wrap = tick && (pre_reg == pre_max);
	assign timeout  = !clear && pre_wrap && (post_reg == post_max);
	assign pre_cnt  = pre_reg;
	assign post_cnt = post_reg;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg  <= {PRE_W{1'b0}};
			post_reg <= {POST_W{1'b0}};
		end else if (clear) begin
			pre_reg  <= {PRE_W{1'b0}};
			post_reg <= {POST_W{1'b0}};
		end else if (tick) begin
			if (pre_wrap) begin
				pre_reg <= {PRE_W{1'b0}};
				if (post_reg == post_max)
					post_reg <= {POST_W{1'b0}};
				else
					post_reg <= post_reg + {{(POST_W-1){1'b0}}, 1'b1};
			end else begin
				pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule
`default_nettype wire

// File: verification/dwt_top_chk.sv
// assertions on the dual watchdog outputs
`timescale 1ns/100ps
`default_nettype none
module dwt_top_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic power_save_instruction,
	input wire logic power_save_idle,
	input wire logic osc_switch_done,
	input wire logic deep_sleep_active,
	input wire logic wdt_reset_request,
	input wire logic wdt_wake_up,
	input wire logic deep_wdt_wake_up,
	input wire logic low_power_rc_osc_enable,
	input wire logic secondary_osc_enable,
	input wire logic power_mode_sleep,
	input wire logic power_mode_idle
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire asleep = power_mode_sleep || power_mode_idle;
	wire osc_on = low_power_rc_osc_enable || secondary_osc_enable;
	wire fired  = wdt_reset_request || wdt_wake_up;
	// a restart leaves at least 32 ticks, far more than 8 cycles
	sequence quiet8;
		!fired [*8];
	endsequence
	rst_pulse_a: assert property (wdt_reset_request |=> !wdt_reset_request)
		else $error("reset request too long");
	wake_pulse_a: assert property (wdt_wake_up |=> !wdt_wake_up)
		else $error("wake pulse too long");
	deep_pulse_a: assert property (deep_wdt_wake_up |=> !deep_wdt_wake_up)
		else $error("deep wake pulse too long");
	wake_mode_a: assert property (wdt_wake_up |-> $past(asleep, 2))
		else $error("wake pulse outside sleep or idle");
	run_reset_a: assert property (wdt_reset_request |-> !$past(asleep, 2))
		else $error("reset request from sleep or idle");
	rc_enable_a: assert property (fired |-> $past(low_power_rc_osc_enable))
		else $error("time-out without RC clock enabled");
	deep_sleep_a: assert property (deep_wdt_wake_up |-> $past(deep_sleep_active) && $past(osc_on))
		else $error("deep wake outside deep sleep");
	mode_excl_a: assert property (!(power_mode_sleep && power_mode_idle))
		else $error("sleep and idle together");
	sleep_enter_a: assert property (power_save_instruction && !power_save_idle && !asleep
		|-> ##[1:2] power_mode_sleep) else $error("sleep not entered");
	restart_quiet_a: assert property (osc_switch_done || power_save_instruction |-> ##2 quiet8)
		else $error("time-out right after restart");
endmodule
`default_nettype wire

// File: verification/dwt_top_bench.sv
// self-checking bench for the dual watchdog
`timescale 1ns/100ps
`default_nettype none
`include "dwt_map.vh"
module dwt_top_bench;
	logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	logic [3:0]  pv = '0;
	logic [2:0]  kind;
	logic        low_power_rc_osc = 0, secondary_osc = 0, power_save_idle = 0;
	logic        deep_sleep_active = 0;
	wire         clear_watchdog_instruction = pv[0];
	wire         power_save_instruction = pv[1];
	wire         wake_event = pv[2];
	wire         osc_switch_done = pv[3];
	wire  [31:0] prdata;
	wire         pready, pslverr, wdt_reset_request, wdt_wake_up, deep_wdt_wake_up;
	wire         low_power_rc_osc_enable, secondary_osc_enable, power_mode_sleep, power_mode_idle;
	int          err_count = 0, check_count = 0, cyc = 0, rq_n = 0, wk_n = 0, dp_n = 0;
	int          seed = 32'h5756, n, e, pre;
	dwt_top dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .low_power_rc_osc, .secondary_osc, .clear_watchdog_instruction,
		.power_save_instruction, .power_save_idle, .wake_event, .osc_switch_done,
		.deep_sleep_active, .wdt_reset_request, .wdt_wake_up, .deep_wdt_wake_up,
		.low_power_rc_osc_enable, .secondary_osc_enable, .power_mode_sleep, .power_mode_idle);
	always #2.5 mclk = ~mclk;
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// pulses are one cycle wide, so they are counted here rather than polled
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		rq_n <= rq_n + (wdt_reset_request === 1'b1);
		wk_n <= wk_n + (wdt_wake_up === 1'b1);
		dp_n <= dp_n + (deep_wdt_wake_up === 1'b1);
		if (cyc == 80000) begin
			err_count++;
			$display("Error at %0t: timeout", $time);
			report_and_stop;
		end
	end
	task automatic chk(input bit ok);
		check_count++;
		if (!ok) begin
			err_count++;
			$display("Error at %0t: check %0d mismatch", $time, check_count);
		end
	endtask
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int b);
		@(posedge mclk);
		pv[b] <= 1'b1;
		@(posedge mclk);
		pv <= '0;
	endtask
	// eight cycles per oscillator tick leave room for the two-flop sync
	task automatic tk(input bit s);
		@(posedge mclk);
		if (s)
			secondary_osc <= 1'b1;
		else
			low_power_rc_osc <= 1'b1;
		repeat (4) @(posedge mclk);
		secondary_osc <= 1'b0;
		low_power_rc_osc <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// restart, p ticks, an event, then count ticks until a pulse appears
	task automatic run(input int p, input int ev, input bit s, input int lim);
		int r0, w0, d0;
		pulse(3);
		repeat (p) tk(s);
		r0 = rq_n;
		w0 = wk_n;
		d0 = dp_n;
		if (ev == 1)
			pulse(0);
		if (ev >= 2) begin
			power_save_idle <= (ev == 3);
			pulse(1);
			@(posedge mclk);
			chk({power_mode_sleep, power_mode_idle} === (ev == 3 ? 2'b01 : 2'b10));
		end
		if (ev == 4) begin
			repeat (5) tk(s);
			pulse(2);
		end
		n = 0;
		repeat (2) @(posedge mclk);
		while (rq_n == r0 && wk_n == w0 && dp_n == d0 && n < lim) begin
			tk(s);
			n++;
		end
		kind = {dp_n != d0, wk_n != w0, rq_n != r0};
	endtask
	function automatic logic [31:0] ctl(bit [3:0] p, bit b, bit wd, bit hw, bit [3:0] k, bit ds);
		return {16'h0, 1'b1, 2'b00, ds, k, hw, wd, 1'b0, b, p};
	endfunction
	initial begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		apb(0, `DWT_OFF_CTRL, 32'h0);
		chk(rd === 32'h9FDF && err === 1'b0);
		apb(0, 12'h010, 32'h0);
		chk(rd === 32'h0 && err === 1'b1);
		apb(1, `DWT_OFF_CTRL, 32'hFFFF_FFFF);
		apb(0, `DWT_OFF_CTRL, 32'h0);
		chk(rd === 32'h9FDF);
		for (int i = 0; i < 10; i++) begin
			bit b;
			int p, ev;
			b = 1'($random(seed));
			p = $unsigned($random(seed)) % 2;
			ev = i % 5;
			e = 1 << ((b ? 7 : 5) + p);
			pre = $unsigned($random(seed)) % (e / 2) + 1;
			apb(1, `DWT_OFF_CTRL, ctl(4'(p), b, 1, 1, 0, 0));
			run(pre, ev, 0, 2048);
			chk(n === (ev == 0 ? e - pre : e) && kind === (ev inside {2, 3} ? 2 : 1));
			chk({power_mode_sleep, power_mode_idle} === 2'b00);
			apb(0, `DWT_OFF_STATUS, 32'h0);
			chk((rd & 32'h3C) === (ev < 2 ? 32'h10 : 32'h10 | 32'h8 >> (ev == 3)));
			apb(1, `DWT_OFF_STATUS, 32'h0);
			apb(0, `DWT_OFF_STATUS, 32'h0);
			chk(rd === 32'h0);
		end
		apb(1, `DWT_OFF_CTRL, ctl(0, 0, 0, 1, 0, 0));
		run(23, 1, 0, 2048);
		chk(n === 0 && kind === 1);
		run(24, 1, 0, 2048);
		chk(n === 32 && kind === 1);
		apb(1, `DWT_OFF_STATUS, 32'h0);
		apb(1, `DWT_OFF_CTRL, ctl(0, 0, 1, 0, 0, 0));
		run(0, 0, 0, 40);
		chk(n === 40 && kind === 0);
		apb(1, `DWT_OFF_STATUS, 32'h20);
		run(0, 0, 0, 2048);
		chk(n === 32 && kind === 1 && low_power_rc_osc_enable === 1'b1);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		apb(0, `DWT_OFF_STATUS, 32'h0);
		chk(rd === 32'h0);
		for (int k = 0; k < 4; k++) begin
			apb(1, `DWT_OFF_CTRL, ctl(0, 0, 1, 0, 4'(k / 2), 1'(k)));
			deep_sleep_active <= 1'b1;
			run(0, 0, !k[0], 1024);
			chk(n === 32 << (k / 2 * 2 + 1) && kind === 4);
			chk((k[0] ? low_power_rc_osc_enable : secondary_osc_enable) === 1'b1);
			deep_sleep_active <= 1'b0;
		end
		report_and_stop;
	end
endmodule
bind dwt_top dwt_top_chk chk (.mclk, .rstn, .power_save_instruction, .power_save_idle,
	.osc_switch_done, .deep_sleep_active, .wdt_reset_request, .wdt_wake_up, .deep_wdt_wake_up,
	.low_power_rc_osc_enable, .secondary_osc_enable, .power_mode_sleep, .power_mode_idle);
`default_nettype wire
